// [common/buck_two_pkg.sv]
// Package for the second step-down converter register group.
// Assumes an upstream serial-interface core delivers decoded byte accesses.
package buck_two_pkg;
  // Register offsets
  localparam logic [7:0] LEVEL_ADDR = 8'h20;
  localparam logic [7:0] MODE_ADDR = 8'h21;
  localparam logic [7:0] SPARE_ADDR = 8'h22;
  localparam logic [7:0] ENSTAT_ADDR = 8'h23;
  // Field positions
  localparam int CODE_LSB = 0;
  localparam int CODE_MSB = 5;
  localparam int RANGE_BIT = 6;
  localparam int MODE_BIT = 0;
  localparam int ON_BIT = 0;
  localparam int GOOD_BIT = 1;
  localparam int EXACT_BIT = 2;
  // Reset values, arbitrary defaults
  localparam logic [5:0] CODE_RST = 6'h00;
  localparam logic RANGE_RST = 1'b1;
  localparam logic MODE_RST = 1'b0;
  localparam logic ON_RST = 1'b0;
  localparam logic EXACT_RST = 1'b0;
  // Range 0 codes below this are not available
  localparam logic [5:0] RANGE0_MIN_CODE = 6'h12;
  // Register access request carried from the serial core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
  // Converter control settings
  typedef struct packed {
    logic on;
    logic forced_pwm;
    logic range;
    logic [5:0] code;
  } conv_ctrl_s;
endpackage : buck_two_pkg

// [design/buck_two_control_registers.sv]
// Register group for the second step-down converter: four 8-bit registers.
// Assumes one-cycle byte access strobes from the serial-interface core.
// How it works
// - Four 8-bit registers at 20h to 23h holding level, mode, spare, enable/status.
// - Mode bit selects forced PWM; enable turns converter on; power-good read.
// - Six-bit level code in bits 5:0 plus range bit 6, both writable.
// - Range 1 codes all valid; range 0 codes below 010010 not available.
// - Unused bit positions are read-only with part-specific read values.
`timescale 1ns/1ns
module buck_two_control_registers #(
  parameter logic [7:0] SPARE_READ = 8'h00 // Arbitrary part-specific pattern
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire buck_two_pkg::reg_req_s req_in,
  input wire logic power_good_in,
  output buck_two_pkg::conv_ctrl_s ctrl_out,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output logic code_invalid_out
);
  buck_two_pkg::conv_ctrl_s ctrl_r, ctrl_nxt;
  logic exact_r, exact_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic inval_r, inval_nxt;

  // Range 0 rejects low codes; range 1 accepts every code
  function automatic logic code_bad(input logic range, input logic [5:0] code);
    code_bad = !range && (code < buck_two_pkg::RANGE0_MIN_CODE);
  endfunction : code_bad

  // Next-state for settings and read port
  always_comb begin
    ctrl_nxt = ctrl_r;
    exact_nxt = exact_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    if (req_in.wr) begin
      unique case (req_in.addr)
        buck_two_pkg::LEVEL_ADDR: begin
          ctrl_nxt.code = req_in.wdata[buck_two_pkg::CODE_MSB:buck_two_pkg::CODE_LSB];
          ctrl_nxt.range = req_in.wdata[buck_two_pkg::RANGE_BIT];
        end
        buck_two_pkg::MODE_ADDR: begin
          ctrl_nxt.forced_pwm = req_in.wdata[buck_two_pkg::MODE_BIT];
        end
        buck_two_pkg::ENSTAT_ADDR: begin
          // enable and write-exact store as written
          ctrl_nxt.on = req_in.wdata[buck_two_pkg::ON_BIT];
          exact_nxt = req_in.wdata[buck_two_pkg::EXACT_BIT];
        end
        default: begin
          // Spare and foreign addresses: nothing writable
        end
      endcase
    end
    if (req_in.rd) begin
      rvalid_nxt = 1'b1;
      unique case (req_in.addr)
        buck_two_pkg::LEVEL_ADDR: begin
          rdata_nxt = SPARE_READ;
          rdata_nxt[buck_two_pkg::CODE_MSB:buck_two_pkg::CODE_LSB] = ctrl_r.code;
          rdata_nxt[buck_two_pkg::RANGE_BIT] = ctrl_r.range;
        end
        buck_two_pkg::MODE_ADDR: begin
          rdata_nxt = SPARE_READ;
          rdata_nxt[buck_two_pkg::MODE_BIT] = ctrl_r.forced_pwm;
        end
        buck_two_pkg::ENSTAT_ADDR: begin
          rdata_nxt = SPARE_READ;
          rdata_nxt[buck_two_pkg::ON_BIT] = ctrl_r.on;
          rdata_nxt[buck_two_pkg::GOOD_BIT] = power_good_in;
          rdata_nxt[buck_two_pkg::EXACT_BIT] = exact_r;
        end
        default: begin
          rdata_nxt = SPARE_READ;
        end
      endcase
    end
    inval_nxt = code_bad(ctrl_nxt.range, ctrl_nxt.code);
  end

  // Register stage; reset loads defaults only
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_r <= '{on: buck_two_pkg::ON_RST, forced_pwm: buck_two_pkg::MODE_RST,
                  range: buck_two_pkg::RANGE_RST, code: buck_two_pkg::CODE_RST};
      exact_r <= buck_two_pkg::EXACT_RST;
      rdata_r <= '0;
      rvalid_r <= 1'b0;
      inval_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      exact_r <= exact_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      inval_r <= inval_nxt;
    end
  end

  assign ctrl_out = ctrl_r;
  assign rdata_out = rdata_r;
  assign rvalid_out = rvalid_r;
  assign code_invalid_out = inval_r;

  // Checks. All properties sample on the rising edge and sleep while reset
  // is low, so defaults loaded by reset are never judged against a request.
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  // Strobe aimed at one register; shared by the per-register access sequences below
  function automatic logic hit(input logic strobe, input logic [7:0] addr,
                               input logic [7:0] target);
    hit = strobe && (addr == target);
  endfunction : hit

  // Writes aimed at each register
  sequence s_level_wr;
    hit(req_in.wr, req_in.addr, buck_two_pkg::LEVEL_ADDR);
  endsequence
  sequence s_mode_wr;
    hit(req_in.wr, req_in.addr, buck_two_pkg::MODE_ADDR);
  endsequence
  sequence s_spare_wr;
    hit(req_in.wr, req_in.addr, buck_two_pkg::SPARE_ADDR);
  endsequence
  sequence s_enstat_wr;
    hit(req_in.wr, req_in.addr, buck_two_pkg::ENSTAT_ADDR);
  endsequence
  // Write outside the group; the serial core may pass any address through
  sequence s_foreign_wr;
    req_in.wr && (req_in.addr < buck_two_pkg::LEVEL_ADDR
                  || req_in.addr > buck_two_pkg::ENSTAT_ADDR);
  endsequence
  // Range 0 write of a code that has no output level
  sequence s_low_code_wr;
    hit(req_in.wr, req_in.addr, buck_two_pkg::LEVEL_ADDR)
    && !req_in.wdata[buck_two_pkg::RANGE_BIT]
    && (req_in.wdata[buck_two_pkg::CODE_MSB:buck_two_pkg::CODE_LSB]
        < buck_two_pkg::RANGE0_MIN_CODE);
  endsequence

  // Reads aimed at each register
  sequence s_level_rd;
    hit(req_in.rd, req_in.addr, buck_two_pkg::LEVEL_ADDR);
  endsequence
  sequence s_mode_rd;
    hit(req_in.rd, req_in.addr, buck_two_pkg::MODE_ADDR);
  endsequence
  sequence s_spare_rd;
    hit(req_in.rd, req_in.addr, buck_two_pkg::SPARE_ADDR);
  endsequence
  sequence s_enstat_rd;
    hit(req_in.rd, req_in.addr, buck_two_pkg::ENSTAT_ADDR);
  endsequence

  // Cycles that leave the settings or the read port alone
  sequence s_no_wr;
    !req_in.wr;
  endsequence
  sequence s_no_rd;
    !req_in.rd;
  endsequence
  // Level write, one cycle with no write, then a read of the same register
  sequence s_level_round_trip;
    s_level_wr ##1 s_no_wr ##1 s_level_rd;
  endsequence

  // level write stores code and range
  a_level_write: assert property (s_level_wr |=>
    ctrl_out.code == $past(req_in.wdata[buck_two_pkg::CODE_MSB:buck_two_pkg::CODE_LSB])
    && ctrl_out.range == $past(req_in.wdata[buck_two_pkg::RANGE_BIT]))
    else $error("level code or range not stored");
  // written level comes back on a later read
  a_level_round: assert property (s_level_round_trip |=> rvalid_out
    && rdata_out[buck_two_pkg::RANGE_BIT] == $past(req_in.wdata[buck_two_pkg::RANGE_BIT], 3)
    && rdata_out[buck_two_pkg::CODE_MSB:buck_two_pkg::CODE_LSB]
       == $past(req_in.wdata[buck_two_pkg::CODE_MSB:buck_two_pkg::CODE_LSB], 3))
    else $error("level round trip wrong");
  // mode and enable writes take effect next cycle
  a_mode_write: assert property (s_mode_wr |=>
    ctrl_out.forced_pwm == $past(req_in.wdata[buck_two_pkg::MODE_BIT]))
    else $error("mode not stored");
  a_enable_write: assert property (s_enstat_wr |=>
    ctrl_out.on == $past(req_in.wdata[buck_two_pkg::ON_BIT]))
    else $error("enable not stored");
  a_mode_readback: assert property (s_mode_rd |=>
    rvalid_out && rdata_out[buck_two_pkg::MODE_BIT] == $past(ctrl_out.forced_pwm))
    else $error("mode readback wrong");
  a_good_read: assert property (s_enstat_rd |=>
    rvalid_out && rdata_out[buck_two_pkg::GOOD_BIT] == $past(power_good_in))
    else $error("power-good read wrong");
  // read sees the settings held before it, even beside a write
  a_level_readback: assert property (s_level_rd |=>
    rdata_out[buck_two_pkg::RANGE_BIT] == $past(ctrl_out.range)
    && rdata_out[buck_two_pkg::CODE_MSB:buck_two_pkg::CODE_LSB] == $past(ctrl_out.code))
    else $error("level readback wrong");
  a_enstat_readback: assert property (s_enstat_rd |=>
    rdata_out[buck_two_pkg::ON_BIT] == $past(ctrl_out.on)
    && rdata_out[buck_two_pkg::EXACT_BIT] == $past(exact_r))
    else $error("enable or write-exact readback wrong");
  // read port answers only a read, and holds between reads
  a_rvalid_pulse: assert property (s_no_rd |=> !rvalid_out)
    else $error("read valid without a read");
  a_rdata_hold: assert property (s_no_rd |=> $stable(rdata_out))
    else $error("read data changed without a read");
  // settings stand until the next write
  a_settings_hold: assert property (s_no_wr |=> $stable(ctrl_out))
    else $error("settings changed without a write");
  // read-only positions show the part pattern
  a_level_readonly: assert property (s_level_rd |=>
    (rdata_out >> (buck_two_pkg::RANGE_BIT + 1))
    == (SPARE_READ >> (buck_two_pkg::RANGE_BIT + 1)))
    else $error("level read-only bit wrong");
  a_mode_readonly: assert property (s_mode_rd |=>
    (rdata_out >> (buck_two_pkg::MODE_BIT + 1))
    == (SPARE_READ >> (buck_two_pkg::MODE_BIT + 1)))
    else $error("mode read-only bits wrong");
  a_enstat_readonly: assert property (s_enstat_rd |=>
    (rdata_out >> (buck_two_pkg::EXACT_BIT + 1))
    == (SPARE_READ >> (buck_two_pkg::EXACT_BIT + 1)))
    else $error("enable read-only bits wrong");
  a_spare_read: assert property (s_spare_rd |=>
    rvalid_out && rdata_out == SPARE_READ)
    else $error("spare read wrong");
  // writes leave other fields and registers alone
  a_spare_ignored: assert property (s_spare_wr |=> $stable(ctrl_out))
    else $error("spare write changed settings");
  a_foreign_ignored: assert property (s_foreign_wr |=> $stable(ctrl_out))
    else $error("foreign write changed settings");
  a_level_others: assert property (s_level_wr |=>
    $stable({ctrl_out.on, ctrl_out.forced_pwm}))
    else $error("level write changed other settings");
  a_mode_others: assert property (s_mode_wr |=>
    $stable({ctrl_out.on, ctrl_out.range, ctrl_out.code}))
    else $error("mode write changed other settings");
  a_enstat_others: assert property (s_enstat_wr |=>
    $stable({ctrl_out.forced_pwm, ctrl_out.range, ctrl_out.code}))
    else $error("enable write changed other settings");
  // unavailable range 0 codes raise the flag; range 1 never does
  a_low_code: assert property (s_low_code_wr |=> code_invalid_out)
    else $error("unavailable code not flagged");
  a_range1_valid: assert property (ctrl_out.range |-> !code_invalid_out)
    else $error("range 1 code flagged");
  a_code_valid: assert property (##1 code_invalid_out ==
    (!ctrl_out.range && ctrl_out.code < buck_two_pkg::RANGE0_MIN_CODE))
    else $error("code validity flag wrong");
endmodule : buck_two_control_registers

// [verif/host_model.sv]
// Host-side model issuing decoded byte accesses to the register group.
// Assumes callers enter its task just after a rising clock edge.
`timescale 1ns/1ns
module host_model (
  input wire logic sys_clk_in,
  output buck_two_pkg::reg_req_s req_out
);
  initial req_out = '0;
  // One strobe cycle per byte, then idle again
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    if (wr && a == buck_two_pkg::ENSTAT_ADDR) d[2] = buck_two_pkg::EXACT_RST;
    req_out = '{wr, !wr, a, d};
    @(posedge sys_clk_in);
    #5 req_out = '0;
  endtask : access
endmodule : host_model

// [verif/buck_two_control_registers_test.sv]
// Self-checking bench for the second converter's register group.
// Assumes the host model makes all accesses; power-good is driven here.
`timescale 1ns/1ns
module buck_two_control_registers_test;
  localparam logic [7:0] SP = 8'ha5; // Non-zero fill shows read-only bits
  logic sys_clk_in = 1'b0, arst_n_in = 1'b0, pg = 1'b0, rv, inv;
  logic on = buck_two_pkg::ON_RST, md = buck_two_pkg::MODE_RST;
  logic [6:0] lvl = {buck_two_pkg::RANGE_RST, buck_two_pkg::CODE_RST};
  logic [7:0] rd;
  logic [7:0] cw [5] = '{8'h11, 8'h12, 8'h80, 8'h3f, 8'hff};
  integer err_count = 0, checks_done = 0, seed = 32'h3729;
  buck_two_pkg::reg_req_s req;
  buck_two_pkg::conv_ctrl_s ctrl;
  always #25 sys_clk_in = ~sys_clk_in;
  host_model host_model_i (.sys_clk_in(sys_clk_in), .req_out(req));
  buck_two_control_registers #(.SPARE_READ(SP)) buck_two_control_registers_i (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .req_in(req),
    .power_good_in(pg), .ctrl_out(ctrl), .rdata_out(rd), .rvalid_out(rv),
    .code_invalid_out(inv));
  // Expected read byte, read-only places show the fill
  function automatic logic [7:0] exp_rd(input logic [7:0] ad);
    case (ad)
      8'h20: exp_rd = {SP[7], lvl};
      8'h21: exp_rd = {SP[7:1], md};
      8'h23: exp_rd = {SP[7:3], buck_two_pkg::EXACT_RST, pg, on};
      default: exp_rd = SP;
    endcase
  endfunction : exp_rd
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One access, then outputs compared one cycle on
  task automatic step(input logic w, input logic [7:0] ad, input logic [7:0] dt);
    host_model_i.access(w, ad, dt);
    if (w && ad == 8'h20) lvl = dt[6:0];
    if (w && ad == 8'h21) md = dt[0];
    if (w && ad == 8'h23) on = dt[0];
    if (!w) chk("rdata", {1'b1, exp_rd(ad)}, {rv, rd});
    chk("ctrl", {on, md, lvl}, ctrl);
    chk("invalid", 9'(!lvl[6] && lvl[5:0] < buck_two_pkg::RANGE0_MIN_CODE), 9'(inv));
    // Let an edge pass so the next request never lands in this time step
    @(posedge sys_clk_in);
    #5;
    chk("rvalid idle", 9'h000, 9'(rv));
  endtask : step
  task automatic conclude;
    $display("Checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  // Reset reads first, then corner codes, then random traffic over addresses 20h to 24h
  initial begin
    repeat (3) @(posedge sys_clk_in);
    #5 arst_n_in = 1'b1;
    for (int i = 0; i < 5; i++) step(1'b0, 8'h20 + 8'(i), 8'h00);
    foreach (cw[i]) begin
      step(1'b1, 8'h20, cw[i]);
      step(1'b0, 8'h20, 8'h00);
    end
    repeat (80) begin
      pg = 1'($random(seed));
      step(1'($random(seed)), 8'h20 + 8'({$random(seed)} % 5), 8'($random(seed)));
    end
    conclude();
  end
endmodule : buck_two_control_registers_test
